/* File: rtl/serial_port_pkg.sv */
// Overview of operation
// (RULE1) read timing low in master: shift current result after conversion completes
// (RULE2) read timing high in master: shift previous result during present conversion
// (RULE3) slave mode accepts a chain input so several converters share one line
// (RULE4) chain input level appears on serial output 16 clock periods after read start
// (RULE5) parallel mode drives shared pins as parallel bits six and seven
// (RULE6) serial output follows the serial clock; results held in a register first
// (RULE7) result shifts out most significant bit first
// (RULE8) output format select picks straight binary or two's complement
// (RULE9) master mode keeps each data bit stable over both generated clock edges
// (RULE10) slave, invert low: output changes on rising edge of external clock
// (RULE11) slave, invert high: output changes on falling edge of external clock
// (RULE12) clock pin is output or input according to clock source select
// (RULE13) clock source low: device is master and drives its own clock
// (RULE14) clock source high: host supplies clock gated by chip select
// (RULE15) serial mode uses some data pins, remaining data pins stay undriven
package serial_port_pkg;
   // ****************
   // register map
   // ****************
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_RESULT = 8'h08;
   localparam int CTRL_W           = 5;
   localparam int CTRL_IFACE_BIT   = 0;
   localparam int CTRL_SRC_BIT     = 1;
   localparam int CTRL_TIMING_BIT  = 2;
   localparam int CTRL_INV_BIT     = 3;
   localparam int CTRL_FMT_BIT     = 4;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
   localparam int STAT_BUSY_BIT    = 0;
   localparam int STAT_FRAME_BIT   = 1;
   // ****************
   // data and timing
   // ****************
   localparam int RESULT_W         = 14;
   localparam int FRAME_W          = 16;
   localparam int PIN_W            = 14;
   localparam int SER_DATA_PIN     = 6;
   localparam int SER_CLK_PIN      = 7;
   localparam int CHAIN_DELAY      = 16;
   localparam int CORE_PERIOD_NS   = 10;
   localparam int QUARTER_NS       = 20;
   localparam int QUARTER_CYC      = (QUARTER_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
   localparam logic [3:0] LAST_BIT = 4'hd;
endpackage

/* File: rtl/shift_link_if.sv */
`timescale 1ns/10ps
interface shift_link_if;
   import serial_port_pkg::*;
   logic               link_clk;
   logic               edge_invert;
   logic               frame_rst;
   logic               chain_in;
   logic [FRAME_W-1:0] word;
   logic               data_out;
   modport core    (output link_clk, edge_invert, frame_rst, chain_in, word, input data_out);
   modport shifter (input link_clk, edge_invert, frame_rst, chain_in, word, output data_out);
endinterface

/* File: rtl/result_shifter.sv */
`timescale 1ns/10ps
module result_shifter (
   shift_link_if.shifter link
);
   import serial_port_pkg::*;
   logic               shift_clk;
   logic [FRAME_W-1:0] sreg_reg;
   logic [FRAME_W-1:0] sreg_next;
   logic [4:0]         cnt_reg;
   logic [4:0]         cnt_next;

   // ****************
   // link side shifter
   // ****************
   assign shift_clk = link.link_clk ^ link.edge_invert; // RULE10 RULE11

   always_comb begin
      if (cnt_reg == 5'h00) begin
         sreg_next = {link.word[FRAME_W-2:0], link.chain_in}; // RULE3 RULE7
      end else begin
         sreg_next = {sreg_reg[FRAME_W-2:0], link.chain_in}; // RULE4
      end
      cnt_next = (cnt_reg == 5'h1f) ? cnt_reg : cnt_reg + 5'h01;
   end

   always_ff @(posedge shift_clk or posedge link.frame_rst) begin
      if (link.frame_rst) begin
         sreg_reg <= '0;
         cnt_reg  <= 5'h00;
      end else begin
         sreg_reg <= sreg_next;
         cnt_reg  <= cnt_next;
      end
   end

   assign link.data_out = (cnt_reg == 5'h00) ? link.word[FRAME_W-1] : sreg_reg[FRAME_W-1]; // RULE6

   // ****************
   // checks
   // ****************
   chk_chain_delay: assert property (@(posedge shift_clk) disable iff (link.frame_rst) // RULE4
      (cnt_reg >= 5'(CHAIN_DELAY)) |-> (link.data_out == $past(link.chain_in, 16)))
      else $error("chain input not seen sixteen periods later");
   cov_chain_pass: cover property (@(posedge shift_clk) disable iff (link.frame_rst)
      cnt_reg == 5'h11);
endmodule

/* File: rtl/serial_result_port.sv */
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module serial_result_port (
   input  wire logic                                core_clk,
   input  wire logic                                reset_n,
   input  wire logic [7:0]                          paddr,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [31:0]                         pwdata,
   input  wire logic [3:0]                          pstrb,
   output      logic [31:0]                         prdata,
   output      logic                                pready,
   output      logic                                pslverr,
   input  wire logic                                conv_start,
   input  wire logic                                conv_done,
   input  wire logic [serial_port_pkg::RESULT_W-1:0] conv_result,
   input  wire logic                                link_clk,
   input  wire logic                                frame_select_n,
   input  wire logic                                chain_input,
   output      logic [serial_port_pkg::PIN_W-1:0]    pin_out,
   output      logic [serial_port_pkg::PIN_W-1:0]    pin_oe
);
   import serial_port_pkg::*;

   typedef enum logic {M_IDLE, M_SHIFT} master_state_type;

   // ****************
   // declarations
   // ****************
   logic [CTRL_W-1:0]   ctrl_reg;
   logic [CTRL_W-1:0]   ctrl_next;
   logic [31:0]         rdata_reg;
   logic [31:0]         rdata_next;
   logic                err_reg;
   logic                err_next;
   logic [RESULT_W-1:0] hold_reg;
   logic [RESULT_W-1:0] hold_next;
   logic                cs_meta_reg;
   logic                cs_sync_reg;
   master_state_type    state_reg;
   master_state_type    state_next;
   logic [1:0]          phase_reg;
   logic [1:0]          phase_next;
   logic [3:0]          bit_reg;
   logic [3:0]          bit_next;
   logic [3:0]          pre_reg;
   logic [3:0]          pre_next;
   logic [RESULT_W-1:0] m_sreg_reg;
   logic [RESULT_W-1:0] m_sreg_next;
   logic                m_out_reg;
   logic                m_out_next;
   logic                m_clk_reg;
   logic                m_clk_next;
   logic                serial_mode;
   logic                slave_mode;
   logic                master_mode;
   logic                frame_active;
   logic                trigger;
   logic                quarter_tick;
   logic [RESULT_W-1:0] trig_word;
   logic                setup;
   logic                access;
   shift_link_if        link();

   function automatic logic [RESULT_W-1:0] fmt_word(input logic [RESULT_W-1:0] raw,
                                                    input logic                twos);
      fmt_word = {raw[RESULT_W-1] ^ twos, raw[RESULT_W-2:0]}; // RULE8
   endfunction

   assign serial_mode  = ctrl_reg[CTRL_IFACE_BIT];
   assign slave_mode   = serial_mode && ctrl_reg[CTRL_SRC_BIT];
   assign master_mode  = serial_mode && !ctrl_reg[CTRL_SRC_BIT];
   assign frame_active = slave_mode && cs_sync_reg;

   // ****************
   // apb slave
   // ****************
   assign setup   = psel && !penable;
   assign access  = psel && penable;
   assign pready  = 1'b1;
   assign pslverr = access && err_reg;
   assign prdata  = rdata_reg;

   always_comb begin
      ctrl_next  = ctrl_reg;
      rdata_next = rdata_reg;
      err_next   = err_reg;
      if (setup) begin
         err_next   = 1'b0;
         rdata_next = 32'h0000_0000;
         unique case (paddr)
            ADDR_CTRL:   rdata_next[CTRL_W-1:0] = ctrl_reg;
            ADDR_STATUS: begin
               rdata_next[STAT_BUSY_BIT]  = (state_reg == M_SHIFT);
               rdata_next[STAT_FRAME_BIT] = frame_active;
            end
            ADDR_RESULT: rdata_next[RESULT_W-1:0] = hold_reg;
            default:     err_next = 1'b1;
         endcase
      end
      if (access && pwrite && !err_reg && paddr == ADDR_CTRL && pstrb[0]) begin
         ctrl_next = pwdata[CTRL_W-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg  <= CTRL_RESET;
         rdata_reg <= 32'h0000_0000;
         err_reg   <= 1'b0;
      end else begin
         ctrl_reg  <= ctrl_next;
         rdata_reg <= rdata_next;
         err_reg   <= err_next;
      end
   end

   // ****************
   // result hold and frame sync
   // ****************
   always_comb begin
      hold_next = hold_reg;
      if (conv_done && !frame_active) begin
         hold_next = fmt_word(conv_result, ctrl_reg[CTRL_FMT_BIT]); // RULE6 RULE8
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_reg    <= '0;
         cs_meta_reg <= 1'b0;
         cs_sync_reg <= 1'b0;
      end else begin
         hold_reg    <= hold_next;
         cs_meta_reg <= !frame_select_n;
         cs_sync_reg <= cs_meta_reg;
      end
   end

   // ****************
   // master shifter
   // ****************
   assign trigger = master_mode && (state_reg == M_IDLE) &&
                    (ctrl_reg[CTRL_TIMING_BIT] ? conv_start : conv_done); // RULE1 RULE2
   assign trig_word = ctrl_reg[CTRL_TIMING_BIT] ? hold_reg :
                      fmt_word(conv_result, ctrl_reg[CTRL_FMT_BIT]);
   assign quarter_tick = (pre_reg == 4'(QUARTER_CYC - 1));

   always_comb begin
      state_next  = state_reg;
      phase_next  = phase_reg;
      bit_next    = bit_reg;
      pre_next    = 4'h0;
      m_sreg_next = m_sreg_reg;
      m_out_next  = m_out_reg;
      m_clk_next  = ctrl_reg[CTRL_INV_BIT];
      unique case (state_reg)
         M_IDLE: begin
            m_out_next = 1'b0;
            if (trigger) begin
               state_next  = M_SHIFT;
               phase_next  = 2'h0;
               bit_next    = 4'h0;
               m_sreg_next = trig_word;
               m_out_next  = trig_word[RESULT_W-1]; // RULE7
            end
         end
         M_SHIFT: begin
            m_clk_next = m_clk_reg;
            pre_next   = quarter_tick ? 4'h0 : pre_reg + 4'h1;
            if (quarter_tick) begin
               phase_next = phase_reg + 2'h1;
               if (phase_reg == 2'h0 || phase_reg == 2'h2) begin
                  m_clk_next = !m_clk_reg; // RULE9
               end
               if (phase_reg == 2'h3) begin
                  m_sreg_next = {m_sreg_reg[RESULT_W-2:0], 1'b0}; // RULE7
                  m_out_next  = m_sreg_reg[RESULT_W-2];
                  bit_next    = bit_reg + 4'h1;
                  if (bit_reg == LAST_BIT) begin
                     state_next = M_IDLE;
                     m_out_next = 1'b0;
                  end
               end
            end
            if (!master_mode) begin
               state_next = M_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg  <= M_IDLE;
         phase_reg  <= 2'h0;
         bit_reg    <= 4'h0;
         pre_reg    <= 4'h0;
         m_sreg_reg <= '0;
         m_out_reg  <= 1'b0;
         m_clk_reg  <= 1'b0;
      end else begin
         state_reg  <= state_next;
         phase_reg  <= phase_next;
         bit_reg    <= bit_next;
         pre_reg    <= pre_next;
         m_sreg_reg <= m_sreg_next;
         m_out_reg  <= m_out_next;
         m_clk_reg  <= m_clk_next;
      end
   end

   // ****************
   // slave link
   // ****************
   assign link.link_clk    = link_clk;
   assign link.edge_invert = ctrl_reg[CTRL_INV_BIT];
   assign link.frame_rst   = !reset_n || frame_select_n || !slave_mode; // RULE14
   assign link.chain_in    = chain_input; // RULE3
   assign link.word        = {hold_reg, {(FRAME_W - RESULT_W){1'b0}}};

   result_shifter shifter (
      .link (link.shifter)
   );

   // ****************
   // pin mux
   // ****************
   always_comb begin
      if (!serial_mode) begin
         pin_out = hold_reg; // RULE5
         pin_oe  = '1;
      end else begin
         pin_out = '0;
         pin_oe  = '0; // RULE15
         pin_oe[SER_DATA_PIN]  = 1'b1;
         pin_out[SER_DATA_PIN] = slave_mode ? link.data_out : m_out_reg; // RULE6
         pin_oe[SER_CLK_PIN]   = master_mode; // RULE12 RULE13
         pin_out[SER_CLK_PIN]  = master_mode && m_clk_reg;
      end
   end

   // ****************
   // checks
   // ****************
   chk_read_after_conv: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE1
      ($rose(state_reg == M_SHIFT) && !ctrl_reg[CTRL_TIMING_BIT]) |-> $past(conv_done))
      else $error("after-conversion read started without conversion done");
   chk_read_during_conv: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE2
      ($rose(state_reg == M_SHIFT) && ctrl_reg[CTRL_TIMING_BIT])
         |-> ($past(conv_start) && m_sreg_reg == $past(hold_reg)))
      else $error("during-conversion read did not send previous result");
   chk_msb_first: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE7
      $rose(state_reg == M_SHIFT) |-> (m_out_reg == m_sreg_reg[RESULT_W-1]))
      else $error("first bit is not the msb");
   chk_format_select: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE8
      (conv_done && !frame_active) |=> (hold_reg[RESULT_W-1] ==
         ($past(conv_result[RESULT_W-1]) ^ $past(ctrl_reg[CTRL_FMT_BIT]))))
      else $error("result format wrong");
   chk_data_stable: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE9
      (state_reg == M_SHIFT && master_mode && $changed(m_clk_reg)) |-> $stable(m_out_reg))
      else $error("data changed at a clock edge");
   chk_parallel_pins: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE5
      !serial_mode |-> (pin_out[SER_CLK_PIN:SER_DATA_PIN] == hold_reg[7:6] && &pin_oe))
      else $error("parallel bits six and seven wrong");
   chk_serial_hiz: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE15
      serial_mode |-> (pin_oe[5:0] == 6'h00 && pin_oe[PIN_W-1:8] == 6'h00))
      else $error("unused data pin driven in serial mode");
   chk_master_clock: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE13
      master_mode |-> (pin_oe[SER_CLK_PIN] && pin_out[SER_CLK_PIN] == m_clk_reg))
      else $error("master clock not driven");
   chk_slave_clock: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE12
      slave_mode |-> !pin_oe[SER_CLK_PIN])
      else $error("clock pin driven in slave mode");
   chk_hold_frozen: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE3
      (conv_done && frame_active) |=> $stable(hold_reg))
      else $error("result changed during a slave frame");
   chk_last_bit: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE6
      (state_reg == M_SHIFT && quarter_tick && phase_reg == 2'h3 && bit_reg == LAST_BIT)
         |=> (state_reg == M_IDLE && !m_out_reg))
      else $error("master read did not end after the last bit");
   chk_trigger_msb: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE7
      trigger |=> (state_reg == M_SHIFT && m_out_reg == $past(trig_word[RESULT_W-1])))
      else $error("master read did not start with the msb");
   chk_clock_rate: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE9
      (state_reg == M_SHIFT && $changed(m_clk_reg)) |-> $past(quarter_tick))
      else $error("master clock changed off a quarter tick");
   chk_unmapped_read: assert property (@(posedge core_clk) disable iff (!reset_n)
      (access && err_reg) |-> (pslverr && prdata == 32'h0000_0000))
      else $error("unmapped access not refused");
   chk_serial_data_oe: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE6
      serial_mode |-> pin_oe[SER_DATA_PIN])
      else $error("serial data pin not driven");

   cov_master_after: cover property (@(posedge core_clk) disable iff (!reset_n)
      $fell(state_reg == M_SHIFT) && !ctrl_reg[CTRL_TIMING_BIT]);
   cov_master_during: cover property (@(posedge core_clk) disable iff (!reset_n)
      $fell(state_reg == M_SHIFT) && ctrl_reg[CTRL_TIMING_BIT]);
   cov_frozen_result: cover property (@(posedge core_clk) disable iff (!reset_n)
      conv_done && frame_active);
   cov_slave_frame: cover property (@(posedge core_clk) disable iff (!reset_n)
      $fell(frame_active));
endmodule

/* File: dv/host_reader.sv */
`timescale 1ns/10ps
// ****************
// host side of the serial result link
// ****************
module host_reader (
   input  wire logic serial_result_out,
   input  wire logic serial_result_clock,
   output      logic link_clk,
   output      logic frame_select_n,
   output      logic chain_input
);
   logic master_on;
   logic inv_sel;
   logic last_bit;
   logic got[$];
   int   slips;
   initial begin
      master_on      = 1'b0;
      inv_sel        = 1'b0;
      last_bit       = 1'b0;
      slips          = 0;
      link_clk       = 1'b0;
      frame_select_n = 1'b1;
      chain_input    = 1'b0;
   end
   // master: take a bit on the leading edge, expect it unchanged on the trailing one
   always @(serial_result_clock) begin
      if (master_on) begin
         if (serial_result_clock !== inv_sel) begin
            last_bit = serial_result_out;
            got.push_back(last_bit);
         end else if (serial_result_out !== last_bit) begin
            slips++;
         end
      end
   end
   // slave: clock runs only while chip select is low, idles at the invert level
   task automatic slave_frame(input logic inv, input int n, input logic [31:0] chain);
      int i;
      link_clk = inv;
      #3 frame_select_n = 1'b0;
      #62.5;
      for (i = 0; i < n; i++) begin
         got.push_back(serial_result_out);
         chain_input = chain[i];
         #62.5 link_clk = ~inv;
         #62.5 link_clk = inv;
      end
      #62.5 frame_select_n = 1'b1;
      chain_input = ~chain_input;
   endtask
endmodule

/* File: dv/adc_serial_result_port_tb.sv */
`timescale 1ns/10ps
module adc_serial_result_port_tb;
   import serial_port_pkg::*;
   logic                core_clk, reset_n, psel, penable, pwrite, conv_start, conv_done;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, rd, ch;
   logic [3:0]          pstrb;
   logic                pready, pslverr, er, inv, fmt, rts, xb;
   logic [RESULT_W-1:0] conv_result, r, e;
   logic [PIN_W-1:0]    pin_out, pin_oe;
   wire                 link_clk, frame_select_n, chain_input;
   int                  miscompares, n_checks, seed, m, b, k;
   serial_result_port serial_result_port_i (.core_clk(core_clk), .reset_n(reset_n),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_start(conv_start), .conv_done(conv_done), .conv_result(conv_result),
      .link_clk(link_clk), .frame_select_n(frame_select_n), .chain_input(chain_input),
      .pin_out(pin_out), .pin_oe(pin_oe));
   host_reader host_reader_i (.serial_result_out(pin_out[SER_DATA_PIN]),
      .serial_result_clock(pin_out[SER_CLK_PIN]), .link_clk(link_clk),
      .frame_select_n(frame_select_n), .chain_input(chain_input));
   // ****************
   // helpers
   // ****************
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int j;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      j = 0;
      do begin
         @(posedge core_clk);
         j++;
      end while (pready !== 1'b1 && j < 50);
      if (pready !== 1'b1) miscompares++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   // sel high gives a conversion-done pulse, low a conversion-start pulse
   task automatic pulse(input logic sel, input logic [RESULT_W-1:0] v);
      conv_result <= v;
      if (sel) conv_done <= 1'b1;
      else conv_start <= 1'b1;
      @(posedge core_clk);
      conv_done <= 1'b0;
      conv_start <= 1'b0;
      @(posedge core_clk);
   endtask
   function automatic logic [RESULT_W-1:0] fmtd(input logic [RESULT_W-1:0] v, input logic f);
      return f ? v ^ 14'h2000 : v;
   endfunction
   // ****************
   // stimulus
   // ****************
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #300000;
      miscompares++;
      complete_run();
   end
   initial begin
      {psel, penable, pwrite, conv_start, conv_done, reset_n} = 6'h00;
      {paddr, pwdata, pstrb, conv_result} = '0;
      pstrb = 4'hf;
      miscompares = 0;
      n_checks = 0;
      seed = 81;
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      check(32'(pin_oe), 32'h3fff);
      apb(1'b0, ADDR_CTRL, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      check({31'h0, er}, 32'h1);
      r = RESULT_W'($random(seed));
      pulse(1'b1, r);
      check(32'(pin_out), 32'(r));
      apb(1'b0, ADDR_RESULT, 32'h0);
      check(rd, 32'(r));
      for (m = 0; m < 8; m++) begin
         {rts, fmt, inv} = 3'(m);
         apb(1'b1, ADDR_CTRL, {27'h0, fmt, inv, rts, 1'b0, 1'b1});
         repeat (4) @(posedge core_clk);
         host_reader_i.inv_sel = inv;
         host_reader_i.got.delete();
         host_reader_i.master_on = 1'b1;
         check(32'(pin_oe), 32'h00c0);
         r = RESULT_W'($random(seed));
         pulse(rts, r);
         apb(1'b0, ADDR_STATUS, 32'h0);
         check({31'h0, rd[STAT_BUSY_BIT]}, 32'h0);
         pulse(~rts, r);
         apb(1'b0, ADDR_STATUS, 32'h0);
         check({31'h0, rd[STAT_BUSY_BIT]}, 32'h1);
         k = 0;
         while (host_reader_i.got.size() < RESULT_W && k < 300) begin
            @(posedge core_clk);
            k++;
         end
         repeat (30) @(posedge core_clk);
         host_reader_i.master_on = 1'b0;
         check(32'(host_reader_i.got.size()), 32'(RESULT_W));
         e = fmtd(r, fmt);
         for (b = 0; b < RESULT_W; b++) begin
            check(32'(host_reader_i.got[b]), 32'(e[RESULT_W-1-b]));
         end
      end
      check(32'(host_reader_i.slips), 32'h0);
      for (m = 0; m < 4; m++) begin
         {fmt, inv} = 2'(m);
         apb(1'b1, ADDR_CTRL, {27'h0, fmt, inv, 1'b0, 1'b1, 1'b1});
         check(32'(pin_oe), 32'h0040);
         r = RESULT_W'($random(seed));
         pulse(1'b1, r);
         repeat (4) @(posedge core_clk);
         ch = $random(seed);
         host_reader_i.got.delete();
         fork
            host_reader_i.slave_frame(inv, 20, ch);
            begin
               repeat (20) @(posedge core_clk);
               apb(1'b0, ADDR_STATUS, 32'h0);
               check({31'h0, rd[STAT_FRAME_BIT]}, 32'h1);
               pulse(1'b1, ~r);
            end
         join
         @(posedge core_clk);
         e = fmtd(r, fmt);
         apb(1'b0, ADDR_RESULT, 32'h0);
         check(rd, 32'(e));
         for (b = 0; b < 20; b++) begin
            xb = (b < 14) ? e[13-b] : (b < 16) ? 1'b0 : ch[b-16];
            check(32'(host_reader_i.got[b]), 32'(xb));
         end
      end
      complete_run();
   end
endmodule
